//--- design/bpc_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the prefetch and cache configuration
package bpc_pkg;
   // ==========================================================
   // register map, byte addresses on the AHB-Lite slave
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_PERIOD = 12'h0b4;
   localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h0b8;
   localparam logic [ADDR_W-1:0] OFF_PREFETCH = 12'h0bc;
   // ==========================================================
   // reset values
   localparam logic [31:0] RST_PERIOD = 32'h0000_0040;
   localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
   localparam logic [31:0] RST_PREFETCH = 32'h030c_1143;
   // ==========================================================
   // field positions
   localparam int BIT_RETRY = 0;
   localparam int BIT_DISCARD = 2;
   localparam int BIT_MULTI_EN = 24;
   localparam int BIT_LINE_EN = 25;
   localparam int BIT_PLAIN_EN = 26;
   localparam int LSB_MULTI_SLOW = 0;
   localparam int LSB_MULTI_FAST = 6;
   localparam int LSB_LINE_SLOW = 12;
   localparam int LSB_LINE_FAST = 18;
   localparam int THR_W = 6;
   localparam int NUM_FLAGS = 2;
   localparam int FLAG_RETRY = 0;
   localparam int FLAG_DISCARD = 1;
   // ==========================================================
   // prefetch amounts in doublewords
   localparam int DW_W = 11;
   localparam logic [DW_W-1:0] DW_ONE = 11'h001;
   localparam logic [DW_W-1:0] DW_TWO = 11'h002;
   localparam logic [DW_W-1:0] DW_PER_CHUNK = 11'h010;
   localparam logic [31:0] CNT_ONE = 32'h0000_0001;
   // ==========================================================
   // AHB-Lite codes
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // ==========================================================
   // enumerations
   typedef enum logic [1:0] {
      CMD_READ = 2'b00,
      CMD_READ_LINE = 2'b01,
      CMD_READ_MULTI = 2'b10
   } bpc_cmd_type;
   typedef enum logic {
      HOLD_IDLE = 1'b0,
      HOLD_WAIT = 1'b1
   } bpc_hold_type;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } bpc_bus_type;
endpackage
`default_nettype wire

//--- design/bpc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// configuration carried from the register file to the engines
interface bpc_cfg_if;
   logic [31:0] period;
   logic plain_en;
   logic line_en;
   logic multi_en;
   logic [5:0] line_fast;
   logic [5:0] line_slow;
   logic [5:0] multi_fast;
   logic [5:0] multi_slow;
   modport owner (output period, plain_en, line_en, multi_en,
      line_fast, line_slow, multi_fast, multi_slow);
   modport user (input period, plain_en, line_en, multi_en,
      line_fast, line_slow, multi_fast, multi_slow);
endinterface
`default_nettype wire

//--- design/bpc_size_calc.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// prefetch amount per read command
module bpc_size_calc
   import bpc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // configuration
   bpc_cfg_if.user cfg,
   // read request
   input wire logic req_valid,
   input wire bpc_cmd_type req_cmd,
   input wire logic bus_fast,
   input wire logic bus_wide,
   input wire logic [7:0] line_dwords,
   // answer
   output logic size_valid,
   output logic [DW_W-1:0] size_dwords
);
   logic [DW_W-1:0] next_size;
   logic [DW_W-1:0] line_dw;

   // threshold n selects (n+1) chunks of 64 bytes
   function automatic logic [DW_W-1:0] chunk_dwords(
      input logic [THR_W-1:0] fast_thr,
      input logic [THR_W-1:0] slow_thr,
      input logic fast);
      logic [DW_W-1:0] n;
      n = {{(DW_W-THR_W){1'b0}}, (fast ? fast_thr : slow_thr)};
      return (n + DW_ONE) * DW_PER_CHUNK;
   endfunction

   assign line_dw = {{(DW_W-8){1'b0}}, line_dwords};

   always_comb
   begin
      next_size = DW_ONE;
      case (req_cmd)
         CMD_READ:
            if (cfg.plain_en)
               next_size = chunk_dwords(cfg.line_fast, cfg.line_slow,
                  bus_fast);
            else
               next_size = bus_wide ? DW_TWO : DW_ONE;
         CMD_READ_LINE:
            next_size = cfg.line_en ? chunk_dwords(cfg.line_fast,
               cfg.line_slow, bus_fast) : line_dw;
         CMD_READ_MULTI:
            next_size = cfg.multi_en ? chunk_dwords(cfg.multi_fast,
               cfg.multi_slow, bus_fast) : DW_W'(line_dw << 1);
         default:
            next_size = DW_ONE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         size_valid <= 1'b0;
         size_dwords <= DW_ONE;
      end
      else if (clk_en)
      begin
         size_valid <= req_valid;
         if (req_valid)
            size_dwords <= next_size;
      end
   end

   plain_off_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && req_valid && req_cmd == CMD_READ && !cfg.plain_en
      |=> size_dwords == ($past(bus_wide) ? DW_TWO : DW_ONE))
      else $error("plain read size wrong with prefetch off");
   plain_on_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && req_valid && req_cmd == CMD_READ && cfg.plain_en
      && bus_fast && cfg.line_fast == 6'h00
      |=> size_valid && size_dwords == DW_PER_CHUNK)
      else $error("plain read size wrong with prefetch on");
   line_size_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && req_valid && req_cmd == CMD_READ_LINE && !cfg.line_en
      |=> size_dwords == {3'h0, $past(line_dwords)})
      else $error("line read not one cacheline");
   multi_size_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && req_valid && req_cmd == CMD_READ_MULTI && !cfg.multi_en
      |=> size_dwords == {2'h0, $past(line_dwords), 1'b0})
      else $error("multiple read not two cachelines");
   max_chunk_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && req_valid && req_cmd == CMD_READ_MULTI && cfg.multi_en
      && !bus_fast && cfg.multi_slow == 6'h3f
      |=> size_dwords == 11'h400)
      else $error("largest threshold not 4096 bytes");
endmodule // bpc_size_calc
`default_nettype wire

//--- design/bpc_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// short-term hold of unclaimed prefetched data
module bpc_hold_timer
   import bpc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // configuration
   bpc_cfg_if.user cfg,
   // data events
   input wire logic park,
   input wire logic claim,
   // state
   output logic holding,
   output logic discard
);
   bpc_hold_type state;
   logic [31:0] count;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= HOLD_IDLE;
         count <= WORD_ZERO;
         holding <= 1'b0;
         discard <= 1'b0;
      end
      else if (clk_en)
      begin
         discard <= 1'b0;
         case (state)
            HOLD_IDLE:
               if (park)
               begin
                  state <= HOLD_WAIT;
                  holding <= 1'b1;
                  count <= CNT_ONE;
               end
            HOLD_WAIT:
               if (claim)
               begin
                  state <= HOLD_IDLE;
                  holding <= 1'b0;
               end
               else if (park)
                  count <= CNT_ONE;
               else if (count >= cfg.period)
               begin
                  state <= HOLD_IDLE;
                  holding <= 1'b0;
                  discard <= 1'b1;
               end
               else
                  count <= count + CNT_ONE;
            default:
            begin
               state <= HOLD_IDLE;
               holding <= 1'b0;
            end
         endcase
      end
   end

   expire_hold_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && state == HOLD_WAIT && !claim && !park
      && count >= cfg.period |=> discard && !holding)
      else $error("hold period passed without discard");
   early_drop_a: assert property (@(posedge clk) disable iff (reset)
      discard |-> $past(count) >= $past(cfg.period) && $past(holding))
      else $error("data discarded before period");
endmodule // bpc_hold_timer
`default_nettype wire

//--- design/bpc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A 32-bit writable period, reset to 64, sets how many clock cycles unclaimed prefetched data is held.
// - Bit 2 of the flags word reads one once the secondary discard timer has expired, zero before, zero at reset.
// - Bit 0 of the flags word reads one once the secondary retry timer has expired, zero before, zero at reset.
// - With plain read prefetch off, a memory read fetches one doubleword on a 32-bit bus and two on a 64-bit bus.
// - With plain read prefetch on, a memory read fetches the line threshold amount for the current bus speed.
// - A read line fetches one cacheline with line prefetch off and the line threshold when on; the enable resets to one.
// - A read multiple fetches two cachelines with multi prefetch off and the multi threshold when on; the enable resets to one.
// - The fast line threshold sits at bits 23:18, resets to 3, and applies on a 66 MHz bus.
// - The slow line threshold sits at bits 17:12, resets to 1, and applies on a 33 MHz bus.
// - The fast multi threshold sits at bits 11:6, resets to 5, and applies on a 66 MHz bus.
// - The slow multi threshold sits at bits 5:0, resets to 3, and applies on a 33 MHz bus.
// - A threshold value n stands for n+1 chunks of 64 bytes, from 64 up to 4096 bytes.
module bpc_top
   import bpc_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // timer events
   input wire logic retry_timer_expired,
   input wire logic retry_timer_restart,
   input wire logic discard_timer_expired,
   input wire logic discard_timer_restart,
   output logic retry_expired_flag,
   output logic discard_expired_flag,
   // read requests from the secondary bus
   input wire logic req_valid,
   input wire bpc_cmd_type req_cmd,
   input wire logic bus_fast,
   input wire logic bus_wide,
   input wire logic [7:0] line_dwords,
   output logic size_valid,
   output logic [DW_W-1:0] size_dwords,
   // prefetched data hold
   input wire logic data_parked,
   input wire logic data_claimed,
   output logic cache_holding,
   output logic cache_discard
);
   // ==========================================================
   // register storage
   logic [31:0] cache_hold_cycles;
   logic plain_read_prefetch_en;
   logic line_read_prefetch_en;
   logic multi_read_prefetch_en;
   logic [THR_W-1:0] line_threshold_fast;
   logic [THR_W-1:0] line_threshold_slow;
   logic [THR_W-1:0] multi_threshold_fast;
   logic [THR_W-1:0] multi_threshold_slow;
   logic [NUM_FLAGS-1:0] expired;
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_clear;

   // ==========================================================
   // bus phase tracking
   bpc_bus_type phase;
   logic [ADDR_W-1:0] dp_addr;
   logic addr_take;
   logic reg_write;
   logic [31:0] read_word;

   function automatic logic hits(input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] offset);
      return addr == offset;
   endfunction

   assign addr_take = hsel && htrans[1] && hready;
   assign reg_write = (phase == BUS_WRITE) && hready;

   // reads take one wait state so hrdata can come from a flop
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phase <= BUS_IDLE;
         dp_addr <= '0;
      end
      else if (clk_en && hready)
      begin
         if (addr_take && hsize == HSIZE_WORD)
         begin
            phase <= hwrite ? BUS_WRITE : BUS_READ;
            dp_addr <= haddr[ADDR_W-1:0];
         end
         else
            phase <= BUS_IDLE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         hreadyout <= 1'b1;
         hrdata <= WORD_ZERO;
      end
      else if (clk_en)
      begin
         if (addr_take && hsize == HSIZE_WORD && !hwrite)
            hreadyout <= 1'b0;
         else if (phase == BUS_READ && !hreadyout)
         begin
            hreadyout <= 1'b1;
            hrdata <= read_word;
         end
      end
   end

   // only OKAY is ever answered, unmapped words included
   always_ff @(posedge clk)
   begin
      if (reset)
         hresp <= HRESP_OKAY;
      else if (clk_en)
         hresp <= HRESP_OKAY;
   end

   // ==========================================================
   // read mux, reserved bits zero
   always_comb
   begin
      read_word = WORD_ZERO;
      if (hits(dp_addr, OFF_PERIOD))
         read_word = cache_hold_cycles;
      else if (hits(dp_addr, OFF_FLAGS))
      begin
         read_word[BIT_DISCARD] = expired[FLAG_DISCARD];
         read_word[BIT_RETRY] = expired[FLAG_RETRY];
      end
      else if (hits(dp_addr, OFF_PREFETCH))
      begin
         read_word[BIT_PLAIN_EN] = plain_read_prefetch_en;
         read_word[BIT_LINE_EN] = line_read_prefetch_en;
         read_word[BIT_MULTI_EN] = multi_read_prefetch_en;
         read_word[LSB_LINE_FAST +: THR_W] = line_threshold_fast;
         read_word[LSB_LINE_SLOW +: THR_W] = line_threshold_slow;
         read_word[LSB_MULTI_FAST +: THR_W] = multi_threshold_fast;
         read_word[LSB_MULTI_SLOW +: THR_W] = multi_threshold_slow;
      end
   end

   // ==========================================================
   // writable registers
   always_ff @(posedge clk)
   begin
      if (reset)
         cache_hold_cycles <= RST_PERIOD;
      else if (clk_en && reg_write && hits(dp_addr, OFF_PERIOD))
         cache_hold_cycles <= hwdata;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         plain_read_prefetch_en <= RST_PREFETCH[BIT_PLAIN_EN];
         line_read_prefetch_en <= RST_PREFETCH[BIT_LINE_EN];
         multi_read_prefetch_en <= RST_PREFETCH[BIT_MULTI_EN];
         line_threshold_fast <= RST_PREFETCH[LSB_LINE_FAST +: THR_W];
         line_threshold_slow <= RST_PREFETCH[LSB_LINE_SLOW +: THR_W];
         multi_threshold_fast <= RST_PREFETCH[LSB_MULTI_FAST +: THR_W];
         multi_threshold_slow <= RST_PREFETCH[LSB_MULTI_SLOW +: THR_W];
      end
      else if (clk_en && reg_write && hits(dp_addr, OFF_PREFETCH))
      begin
         plain_read_prefetch_en <= hwdata[BIT_PLAIN_EN];
         line_read_prefetch_en <= hwdata[BIT_LINE_EN];
         multi_read_prefetch_en <= hwdata[BIT_MULTI_EN];
         line_threshold_fast <= hwdata[LSB_LINE_FAST +: THR_W];
         line_threshold_slow <= hwdata[LSB_LINE_SLOW +: THR_W];
         multi_threshold_fast <= hwdata[LSB_MULTI_FAST +: THR_W];
         multi_threshold_slow <= hwdata[LSB_MULTI_SLOW +: THR_W];
      end
   end

   // ==========================================================
   // expiry flags: set wins over a simultaneous restart
   assign flag_set[FLAG_RETRY] = retry_timer_expired;
   assign flag_set[FLAG_DISCARD] = discard_timer_expired;
   assign flag_clear[FLAG_RETRY] = retry_timer_restart;
   assign flag_clear[FLAG_DISCARD] = discard_timer_restart;

   generate
      for (genvar i = 0; i < NUM_FLAGS; i++)
      begin : g_flag
         always_ff @(posedge clk)
         begin
            if (reset)
               expired[i] <= RST_FLAGS[i];
            else if (clk_en)
            begin
               if (flag_set[i])
                  expired[i] <= 1'b1;
               else if (flag_clear[i])
                  expired[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign retry_expired_flag = expired[FLAG_RETRY];
   assign discard_expired_flag = expired[FLAG_DISCARD];

   // ==========================================================
   // engines
   bpc_cfg_if cfg ();

   assign cfg.period = cache_hold_cycles;
   assign cfg.plain_en = plain_read_prefetch_en;
   assign cfg.line_en = line_read_prefetch_en;
   assign cfg.multi_en = multi_read_prefetch_en;
   assign cfg.line_fast = line_threshold_fast;
   assign cfg.line_slow = line_threshold_slow;
   assign cfg.multi_fast = multi_threshold_fast;
   assign cfg.multi_slow = multi_threshold_slow;

   bpc_size_calc u_size (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .cfg(cfg),
      .req_valid(req_valid),
      .req_cmd(req_cmd),
      .bus_fast(bus_fast),
      .bus_wide(bus_wide),
      .line_dwords(line_dwords),
      .size_valid(size_valid),
      .size_dwords(size_dwords)
   );

   bpc_hold_timer u_hold (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .cfg(cfg),
      .park(data_parked),
      .claim(data_claimed),
      .holding(cache_holding),
      .discard(cache_discard)
   );

   // ==========================================================
   // checks
   period_write_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && reg_write && dp_addr == OFF_PERIOD
      |=> cache_hold_cycles == $past(hwdata))
      else $error("period write not taken");
   discard_flag_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && discard_timer_expired
      |=> discard_expired_flag ##1 (phase != BUS_READ || hreadyout
      || dp_addr != OFF_FLAGS || read_word[BIT_DISCARD]))
      else $error("discard flag not set on expiry");
   retry_flag_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && retry_timer_expired && !retry_timer_restart
      |=> retry_expired_flag)
      else $error("retry flag not set on expiry");
   retry_clear_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && retry_timer_restart && !retry_timer_expired
      |=> !retry_expired_flag)
      else $error("retry flag not cleared on restart");
   line_fast_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && reg_write && dp_addr == OFF_PREFETCH
      |=> line_threshold_fast == $past(hwdata[23:18]))
      else $error("fast line threshold misplaced");
   line_slow_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && reg_write && dp_addr == OFF_PREFETCH
      |=> line_threshold_slow == $past(hwdata[17:12]))
      else $error("slow line threshold misplaced");
   multi_fast_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && reg_write && dp_addr == OFF_PREFETCH
      |=> multi_threshold_fast == $past(hwdata[11:6]))
      else $error("fast multi threshold misplaced");
   multi_slow_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && reg_write && dp_addr == OFF_PREFETCH
      |=> multi_threshold_slow == $past(hwdata[5:0]))
      else $error("slow multi threshold misplaced");
   read_wait_a: assert property (@(posedge clk) disable iff (reset)
      clk_en && addr_take && hsize == HSIZE_WORD && !hwrite
      |=> !hreadyout ##1 hreadyout)
      else $error("read wait state not one cycle");
endmodule // bpc_top
`default_nettype wire

//--- verification/bpc_pci_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// secondary bus master: read requests and unclaimed data
module bpc_pci_master
   import bpc_pkg::*;
(
   // clock
   input wire logic clk,
   // read request
   output logic req_valid,
   output bpc_cmd_type req_cmd,
   output logic bus_fast,
   output logic bus_wide,
   output logic [7:0] line_dwords,
   // prefetched data
   output logic data_parked,
   output logic data_claimed
);
   initial
   begin
      req_valid = 1'b0;
      req_cmd = CMD_READ;
      bus_fast = 1'b0;
      bus_wide = 1'b0;
      line_dwords = 8'h08;
      data_parked = 1'b0;
      data_claimed = 1'b0;
   end

   // a spare edge after each pulse keeps two requests from merging
   task automatic read(input bpc_cmd_type c, input logic f, input logic w,
      input logic [7:0] l);
      req_valid <= 1'b1;
      req_cmd <= c;
      bus_fast <= f;
      bus_wide <= w;
      line_dwords <= l;
      @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
   endtask

   task automatic leave(input logic claim);
      data_parked <= !claim;
      data_claimed <= claim;
      @(posedge clk);
      data_parked <= 1'b0;
      data_claimed <= 1'b0;
      @(posedge clk);
   endtask
endmodule // bpc_pci_master
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import bpc_pkg::*;;
   logic clk, reset, hwrite, rd_phase, hreadyout, hresp, size_valid;
   logic rv, rfast, rwide, park, claim, rflag, dflag, hold, disc;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] tev;
   logic [7:0] rline;
   logic [31:0] haddr, hwdata, hrdata, prefetch_size_control, lfsr, v;
   logic [DW_W-1:0] size_dwords;
   bpc_cmd_type rcmd;
   int bad_count, n_tests;
   logic [31:0] rq[$];
   logic [DW_W-1:0] sq[$];

   bpc_pci_master i_pm (.clk(clk), .req_valid(rv), .req_cmd(rcmd),
      .bus_fast(rfast), .bus_wide(rwide), .line_dwords(rline),
      .data_parked(park), .data_claimed(claim));
   bpc_top i_dut (.clk(clk), .reset(reset), .clk_en(1'b1), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .retry_timer_expired(tev[0]),
      .retry_timer_restart(tev[1]), .discard_timer_expired(tev[2]),
      .discard_timer_restart(tev[3]), .retry_expired_flag(rflag),
      .discard_expired_flag(dflag), .req_valid(rv), .req_cmd(rcmd),
      .bus_fast(rfast), .bus_wide(rwide), .line_dwords(rline),
      .size_valid(size_valid), .size_dwords(size_dwords),
      .data_parked(park), .data_claimed(claim), .cache_holding(hold),
      .cache_discard(disc));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ==========================================================
   // checking
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   always @(posedge clk)
   begin
      if (size_valid === 1'b1)
         chk({21'h0, size_dwords}, {21'h0, sq.pop_front()});
      if (rd_phase && hreadyout === 1'b1)
      begin
         chk(hrdata, rq.pop_front());
         chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [DW_W-1:0] exp_size(input int c, input logic f,
      input logic w, input logic [7:0] l);
      logic [6:0] lt;
      logic [6:0] mt;
      lt = 7'(f ? prefetch_size_control[23:18] : prefetch_size_control[17:12]) + 7'd1;
      mt = 7'(f ? prefetch_size_control[11:6] : prefetch_size_control[5:0]) + 7'd1;
      case (c)
         0: return prefetch_size_control[26] ? {lt, 4'h0} : (w ? DW_TWO : DW_ONE);
         1: return prefetch_size_control[25] ? {lt, 4'h0} : {3'h0, l};
         default: return prefetch_size_control[24] ? {mt, 4'h0} : {2'h0, l, 1'b0};
      endcase
   endfunction

   // ==========================================================
   // drivers
   task automatic ahb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
      htrans <= 2'b10;
      haddr <= 32'(a);
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      rd_phase <= !w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd_phase <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rq.push_back(e);
      ahb(a, 1'b0, WORD_ZERO);
   endtask

   // flag pins are long settled once the read has ended
   task automatic flag_rd(input logic [31:0] e);
      rd(OFF_FLAGS, e);
      chk({29'h0, dflag, 1'b0, rflag}, e);
   endtask

   task automatic sweep(input logic [7:0] l);
      for (int i = 0; i < 13; i++)
      begin
         sq.push_back(i == 12 ? DW_ONE
            : exp_size(i % 3, (i / 3) % 2 == 1, i >= 6, l));
         i_pm.read(bpc_cmd_type'(2'(i == 12 ? 3 : i % 3)),
            (i / 3) % 2 == 1, i >= 6, l);
      end
   endtask

   task automatic pulse(input int b);
      tev[b] <= 1'b1;
      @(posedge clk);
      tev[b] <= 1'b0;
   endtask

   // count from the edge after parking to the discard pulse
   task automatic hold_run(input logic claim_it, input int exp);
      int n;
      n = 0;
      i_pm.leave(1'b0);
      chk({31'h0, hold}, 32'h0000_0001);
      if (claim_it)
         i_pm.leave(1'b1);
      do
      begin
         @(posedge clk);
         n++;
      end
      while (disc !== 1'b1 && n < 80);
      chk(n, exp);
      chk({31'h0, hold}, 32'h0);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      bad_count++;
      end_of_test();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      reset = 1'b1;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = WORD_ZERO;
      rd_phase = 1'b0;
      tev = 4'h0;
      bad_count = 0;
      n_tests = 0;
      lfsr = 32'd62;
      prefetch_size_control = RST_PREFETCH;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(OFF_PERIOD, 32'h0000_0040);
      flag_rd(WORD_ZERO);
      rd(OFF_PREFETCH, 32'h030c_1143);
      rd(12'h0c0, WORD_ZERO);
      sweep(8'h08);
      $display("reset values done");
      // all-ones and all-zero thresholds give the boundaries;
      // the second word also turns plain prefetch on, others off
      for (int k = 0; k < 6; k++)
      begin
         lfsr = lfsr_next(lfsr);
         v = k == 0 ? 32'hffff_ffff : (k == 1 ? 32'h0400_0000 : lfsr);
         ahb(OFF_PREFETCH, 1'b1, v);
         prefetch_size_control = v & 32'h07ff_ffff;
         rd(OFF_PREFETCH, prefetch_size_control);
         sweep(v[31:24]);
      end
      $display("prefetch sizes done");
      pulse(0);
      flag_rd(32'h0000_0001);
      ahb(OFF_FLAGS, 1'b1, WORD_ZERO);
      pulse(2);
      flag_rd(32'h0000_0005);
      pulse(1);
      flag_rd(32'h0000_0004);
      pulse(3);
      flag_rd(WORD_ZERO);
      $display("flags done");
      hold_run(1'b0, 64);
      ahb(OFF_PERIOD, 1'b1, 32'h0000_0005);
      rd(OFF_PERIOD, 32'h0000_0005);
      hold_run(1'b0, 5);
      hold_run(1'b1, 80);
      ahb(OFF_PERIOD, 1'b1, 32'h0000_0001);
      hold_run(1'b0, 1);
      $display("hold done");
      repeat (4) @(posedge clk);
      // every noted answer must have been seen
      chk(32'(sq.size() + rq.size()), WORD_ZERO);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
